/* File: hdl/ptcb_pkg.sv */
// package of the timer and counter bank: register map, command layout,
// timer and counter kinds, time bases and tick timing.
// assumes a 10 MHz aclk and a 32-bit axi4-lite register bus.
package ptcb_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL  = 8'h00; // bit 0: scan start (write 1)
	localparam logic [7:0] REG_CMD   = 8'h04; // write executes one instruction
	localparam logic [7:0] REG_SEL   = 8'h08; // readback index
	localparam logic [7:0] REG_TSTAT = 8'h0c; // selected timer state
	localparam logic [7:0] REG_CSTAT = 8'h10; // selected counter state
	localparam logic [7:0] REG_STAT  = 8'h14; // engine state

	// field positions in control and status words
	localparam int CTRL_SCAN_BIT = 0;
	localparam int STAT_Q_BIT    = 16;
	localparam int STAT_ACT_BIT  = 17;
	localparam int STAT_ARM_BIT  = 18;

	// instruction operations
	localparam logic [1:0] OP_T_EXEC  = 2'h0;
	localparam logic [1:0] OP_T_RESET = 2'h1;
	localparam logic [1:0] OP_C_EXEC  = 2'h2;
	localparam logic [1:0] OP_C_RESET = 2'h3;

	// timer kinds and counter kinds
	localparam logic [1:0] TK_ON  = 2'h0; // on_delay_timer
	localparam logic [1:0] TK_ACC = 2'h1; // accumulating_delay_timer
	localparam logic [1:0] TK_OFF = 2'h2; // off_delay_timer
	localparam logic [1:0] CK_UP  = 2'h0; // up_counter
	localparam logic [1:0] CK_BI  = 2'h1; // bidirectional_counter
	localparam logic [1:0] CK_DN  = 2'h2; // down_counter

	// value limits and reset values
	localparam logic [15:0] VAL_MAX  = 16'h7fff;
	localparam logic [15:0] VAL_ZERO = 16'h0000;
	localparam logic [7:0]  SEL_RST  = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// bank size
	localparam int NUM_IDX = 256;

	// time bases
	typedef enum logic [1:0] {
		RES_1MS   = 2'b00,
		RES_10MS  = 2'b01,
		RES_100MS = 2'b10
	} ptcb_res_e;
	localparam int TICK_MS       = 1;    // base tick, ms
	localparam int CLK_PERIOD_NS = 100;  // aclk period, ns
	localparam int MS_CYCLES     = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [3:0] DIV10_LAST = 4'h9; // ten ticks per coarser base

	// one instruction word as written to the command register
	typedef struct packed {
		logic [15:0] preset; // delay_preset or count_preset
		logic        load;   // preload_input
		logic        rst;    // reset input
		logic        dn;     // down_pulse_input
		logic        en;     // enable, or up_pulse_input
		logic [1:0]  kind;
		logic [1:0]  op;
		logic [7:0]  idx;
	} ptcb_cmd_s;

	// time base fixed by timer index
	function automatic ptcb_res_e ptcb_res_of(input logic [7:0] idx);
		logic [5:0] low;
		low = idx[5:0];
		if (idx[7])
			return RES_100MS;
		if (low == 6'h00 || low == 6'h20)
			return RES_1MS;
		if ((low >= 6'h01 && low <= 6'h04) || (low >= 6'h21 && low <= 6'h24))
			return RES_10MS;
		return RES_100MS;
	endfunction

endpackage

/* File: hdl/ptcb_timer_step.sv */
// one timer update: adds elapsed intervals and derives the timer bit.
// assumes the caller has already applied enable and reset effects.
`timescale 1ns/1ps
module ptcb_timer_step
	import ptcb_pkg::*;
(
	input  wire logic [1:0]  kind,
	input  wire logic [15:0] cur,
	input  wire logic [15:0] preset,
	input  wire logic [15:0] inc,
	input  wire logic        active,
	input  wire logic        q,
	output logic      [15:0] cur_o,
	output logic             q_o,
	output logic             active_o
);
	logic [16:0] sum;
	logic [15:0] sat;
	logic        reach;

	// saturating sum and preset compare
	assign sum   = {1'b0, cur} + {1'b0, inc};
	assign sat   = (sum > {1'b0, VAL_MAX}) ? VAL_MAX : sum[15:0];
	assign reach = sat >= preset;

	// advance only while active
	always_comb
	begin
		cur_o    = cur;
		q_o      = q;
		active_o = active;
		if (active)
		begin
			if (kind == TK_OFF)
			begin
				if (reach)
				begin
					cur_o    = preset;
					q_o      = 1'b0;
					active_o = 1'b0;
				end
				else
					cur_o = sat;
			end
			else
			begin
				cur_o = sat;
				q_o   = reach;
			end
		end
	end
endmodule

/* File: hdl/ptcb_count_step.sv */
// one counter update from edge flags, reset and preload.
// assumes edges were already detected against the stored input levels.
`timescale 1ns/1ps
module ptcb_count_step
	import ptcb_pkg::*;
(
	input  wire logic [1:0]  kind,
	input  wire logic [15:0] cur,
	input  wire logic [15:0] preset,
	input  wire logic        up_rise,
	input  wire logic        dn_rise,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic        q,
	output logic      [15:0] cur_o,
	output logic             q_o
);
	// per-kind counting
	always_comb
	begin
		cur_o = cur;
		q_o   = q;
		case (kind)
			CK_UP:
			begin
				if (rst)
				begin
					cur_o = VAL_ZERO;
					q_o   = 1'b0;
				end
				else
				begin
					if (up_rise && cur != VAL_MAX)
						cur_o = cur + 16'h0001;
					q_o = $signed(cur_o) >= $signed(preset);
				end
			end
			CK_BI:
			begin
				if (rst)
				begin
					cur_o = VAL_ZERO;
					q_o   = 1'b0;
				end
				else
				begin
					if (up_rise && !dn_rise)
						cur_o = cur + 16'h0001;
					else if (dn_rise && !up_rise)
						cur_o = cur - 16'h0001;
					q_o = $signed(cur_o) >= $signed(preset);
				end
			end
			CK_DN:
			begin
				if (load)
				begin
					cur_o = preset;
					q_o   = 1'b0;
				end
				else
				begin
					if (dn_rise && $signed(cur) > $signed(VAL_ZERO))
						cur_o = cur - 16'h0001;
					q_o = cur_o == VAL_ZERO;
				end
			end
			default:
			begin
				cur_o = cur;
				q_o   = q;
			end
		endcase
	end
endmodule

/* File: hdl/ptcb_bank.sv */
// top of the timer and counter bank, an axi4-lite slave.
// assumes the scan executor writes one instruction per command write
// and marks each scan start through the control register.
`timescale 1ns/1ps
module ptcb_bank
	import ptcb_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef enum logic {
		SW_IDLE = 1'b0,
		SW_RUN  = 1'b1
	} ptcb_sweep_e;

	// timer and counter state memories
	logic [15:0] t_cur  [NUM_IDX];
	logic [15:0] t_pre  [NUM_IDX];
	logic [1:0]  t_kind [NUM_IDX];
	logic        t_q    [NUM_IDX];
	logic        t_act  [NUM_IDX];
	logic        t_arm  [NUM_IDX];
	logic [15:0] c_cur  [NUM_IDX];
	logic        c_q    [NUM_IDX];
	logic        c_up   [NUM_IDX];
	logic        c_dn   [NUM_IDX];

	// bus holding registers
	logic        aw_full;
	logic [7:0]  aw_addr;
	logic        w_full;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic [7:0]  sel;
	logic [31:0] cmd_last;

	// time bases
	logic [31:0] ms_cnt;
	logic [3:0]  d10;
	logic [3:0]  d100;
	logic [15:0] acc10;
	logic [15:0] acc100;
	logic [15:0] add10;
	logic [15:0] last100;

	// sweep engine
	ptcb_sweep_e state;
	logic [7:0]  sw_idx;
	logic        init_pend;
	logic        tick_pend;
	logic        scan_pend;
	logic        sw_clr;
	logic        sw_tick;
	logic        sw_scan;

	// byte-lane mask from write strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// write decode
	logic        busy;
	logic        do_write;
	logic [31:0] w_eff;
	ptcb_cmd_s   cmd;
	logic        wr_ctrl;
	logic        wr_cmd;
	logic        wr_sel;
	logic        wr_map;
	logic        scan_req;
	assign busy     = state == SW_RUN;
	assign do_write = aw_full && w_full && !s_axi_bvalid && !busy;
	assign w_eff    = w_data & lane_mask(w_strb);
	assign cmd      = ptcb_cmd_s'(w_eff);
	assign wr_ctrl  = do_write && aw_addr == REG_CTRL;
	assign wr_cmd   = do_write && aw_addr == REG_CMD;
	assign wr_sel   = do_write && aw_addr == REG_SEL;
	assign wr_map   = aw_addr == REG_CTRL || aw_addr == REG_CMD || aw_addr == REG_SEL
		|| aw_addr == REG_TSTAT || aw_addr == REG_CSTAT || aw_addr == REG_STAT;
	assign scan_req = wr_ctrl && w_eff[CTRL_SCAN_BIT];

	// handshake outputs
	assign s_axi_awready = !aw_full;
	assign s_axi_wready  = !w_full;
	assign s_axi_arready = !s_axi_rvalid;

	// millisecond tick and the two coarser bases
	logic ms_tick;
	logic tick10;
	logic tick100;
	assign ms_tick = ms_cnt == 32'(MS_CYC - 1);
	assign tick10  = ms_tick && d10 == DIV10_LAST;
	assign tick100 = tick10 && d100 == DIV10_LAST;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ms_cnt <= '0;
			d10    <= '0;
			d100   <= '0;
		end
		else
		begin
			ms_cnt <= ms_tick ? '0 : ms_cnt + 32'h1;
			d10    <= ms_tick ? (tick10 ? 4'h0 : d10 + 4'h1) : d10;
			d100   <= tick10 ? (tick100 ? 4'h0 : d100 + 4'h1) : d100;
		end
	end

	// interval accumulators, snapshot at each scan start
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc10   <= '0;
			acc100  <= '0;
			add10   <= '0;
			last100 <= '0;
		end
		else if (scan_req)
		begin
			add10   <= acc10 + {15'h0, tick10};
			last100 <= acc100 + {15'h0, tick100};
			acc10   <= '0;
			acc100  <= '0;
		end
		else
		begin
			acc10  <= acc10 + {15'h0, tick10};
			acc100 <= acc100 + {15'h0, tick100};
		end
	end

	// sweep start and pending events; a new event beats the clear
	logic sw_go;
	logic sw_last;
	assign sw_go   = state == SW_IDLE && (init_pend || tick_pend || scan_pend) && !do_write;
	assign sw_last = sw_idx == 8'hff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state     <= SW_IDLE;
			sw_idx    <= '0;
			init_pend <= 1'b1;
			tick_pend <= 1'b0;
			scan_pend <= 1'b0;
			sw_clr    <= 1'b0;
			sw_tick   <= 1'b0;
			sw_scan   <= 1'b0;
		end
		else
		begin
			tick_pend <= ms_tick || (tick_pend && !sw_go);
			scan_pend <= scan_req || (scan_pend && !sw_go);
			case (state)
				SW_IDLE:
				begin
					if (sw_go)
					begin
						state     <= SW_RUN;
						sw_idx    <= '0;
						sw_clr    <= init_pend;
						sw_tick   <= tick_pend && !init_pend;
						sw_scan   <= scan_pend && !init_pend;
						init_pend <= 1'b0;
					end
				end
				SW_RUN:
				begin
					sw_idx <= sw_idx + 8'h1;
					if (sw_last)
						state <= SW_IDLE;
				end
				default:
					state <= SW_IDLE;
			endcase
		end
	end

	// increment seen by the timer under the sweep
	ptcb_res_e sw_res;
	ptcb_res_e cmd_res;
	logic [15:0] sw_inc;
	assign sw_res = ptcb_res_of(sw_idx);
	assign sw_inc = (sw_res == RES_1MS && sw_tick) ? 16'h0001
		: (sw_res == RES_10MS && sw_scan) ? add10 : VAL_ZERO;

	// command pre-stage: enable effects before time is added
	logic [15:0] o_cur;
	logic        o_q;
	logic        o_arm;
	logic        is_off;
	logic        is_on;
	logic [15:0] pre_cur;
	logic        pre_q;
	logic        pre_act;
	logic        pre_arm;
	logic [15:0] cmd_inc;
	assign o_cur   = t_cur[cmd.idx];
	assign o_q     = t_q[cmd.idx];
	assign o_arm   = t_arm[cmd.idx];
	assign is_off  = cmd.kind == TK_OFF;
	assign is_on   = cmd.kind == TK_ON;
	assign cmd_res = ptcb_res_of(cmd.idx);
	assign pre_cur = cmd.en ? (is_off ? VAL_ZERO : o_cur)
		: (is_on ? VAL_ZERO : o_cur);
	assign pre_q   = cmd.en ? (is_off ? 1'b1 : o_q) : (is_on ? 1'b0 : o_q);
	assign pre_act = cmd.en ? !is_off : (is_off && o_arm);
	assign pre_arm = cmd.en || o_arm;
	assign cmd_inc = (cmd_res == RES_100MS && pre_act) ? last100 : VAL_ZERO;

	// shared timer step, fed by the sweep or the command
	logic [1:0]  st_kind;
	logic [15:0] st_cur;
	logic [15:0] st_pre;
	logic [15:0] st_inc;
	logic        st_act;
	logic        st_q;
	logic [15:0] st_cur_o;
	logic        st_q_o;
	logic        st_act_o;
	logic        arm_base;
	logic        arm_w;
	assign st_kind  = busy ? t_kind[sw_idx] : cmd.kind;
	assign st_cur   = busy ? t_cur[sw_idx] : pre_cur;
	assign st_pre   = busy ? t_pre[sw_idx] : cmd.preset;
	assign st_inc   = busy ? sw_inc : cmd_inc;
	assign st_act   = busy ? t_act[sw_idx] : pre_act;
	assign st_q     = busy ? t_q[sw_idx] : pre_q;
	assign arm_base = busy ? t_arm[sw_idx] : pre_arm;
	assign arm_w    = (st_kind == TK_OFF && st_act) ? (arm_base && st_act_o) // disarm at end only
		: arm_base;

	ptcb_timer_step u_timer_step (
		.kind     (st_kind),
		.cur      (st_cur),
		.preset   (st_pre),
		.inc      (st_inc),
		.active   (st_act),
		.q        (st_q),
		.cur_o    (st_cur_o),
		.q_o      (st_q_o),
		.active_o (st_act_o)
	);

	// timer memory write port
	logic t_exec;
	logic t_rst;
	assign t_exec = wr_cmd && cmd.op == OP_T_EXEC;
	assign t_rst  = wr_cmd && cmd.op == OP_T_RESET;

	always_ff @(posedge aclk)
	begin
		if (busy && sw_clr)
		begin
			t_cur[sw_idx]  <= VAL_ZERO;
			t_q[sw_idx]    <= 1'b0;
			t_act[sw_idx]  <= 1'b0;
			t_arm[sw_idx]  <= 1'b0;
			t_kind[sw_idx] <= TK_ON;
			t_pre[sw_idx]  <= VAL_ZERO;
		end
		else if (busy)
		begin
			t_cur[sw_idx] <= st_cur_o;
			t_q[sw_idx]   <= st_q_o;
			t_act[sw_idx] <= st_act_o;
			t_arm[sw_idx] <= arm_w;
		end
		else if (t_rst)
		begin
			t_cur[cmd.idx] <= VAL_ZERO;
			t_q[cmd.idx]   <= 1'b0;
			t_act[cmd.idx] <= 1'b0;
			t_arm[cmd.idx] <= 1'b0;
		end
		else if (t_exec)
		begin
			t_cur[cmd.idx]  <= st_cur_o;
			t_q[cmd.idx]    <= st_q_o;
			t_act[cmd.idx]  <= st_act_o;
			t_arm[cmd.idx]  <= arm_w;
			t_kind[cmd.idx] <= cmd.kind;
			t_pre[cmd.idx]  <= cmd.preset;
		end
	end

	// counter step with edge detection against stored input levels
	logic [15:0] c_cur_o;
	logic        c_q_o;
	logic        up_rise;
	logic        dn_rise;
	assign up_rise = cmd.en && !c_up[cmd.idx];
	assign dn_rise = cmd.dn && !c_dn[cmd.idx];

	ptcb_count_step u_count_step (
		.kind    (cmd.kind),
		.cur     (c_cur[cmd.idx]),
		.preset  (cmd.preset),
		.up_rise (up_rise),
		.dn_rise (dn_rise),
		.rst     (cmd.rst),
		.load    (cmd.load),
		.q       (c_q[cmd.idx]),
		.cur_o   (c_cur_o),
		.q_o     (c_q_o)
	);

	// counter memory write port, one entry per index
	always_ff @(posedge aclk)
	begin
		if (busy && sw_clr)
		begin
			c_cur[sw_idx] <= VAL_ZERO;
			c_q[sw_idx]   <= 1'b0;
			c_up[sw_idx]  <= 1'b0;
			c_dn[sw_idx]  <= 1'b0;
		end
		else if (wr_cmd && cmd.op == OP_C_EXEC)
		begin
			c_cur[cmd.idx] <= c_cur_o;
			c_q[cmd.idx]   <= c_q_o;
			c_up[cmd.idx]  <= cmd.en;
			c_dn[cmd.idx]  <= cmd.dn;
		end
		else if (wr_cmd && cmd.op == OP_C_RESET)
		begin
			c_cur[cmd.idx] <= VAL_ZERO;
			c_q[cmd.idx]   <= 1'b0;
		end
	end

	// write channels: address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full      <= 1'b0;
			aw_addr      <= '0;
			w_full       <= 1'b0;
			w_data       <= '0;
			w_strb       <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			sel          <= SEL_RST;
			cmd_last     <= '0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full)
			begin
				aw_full <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_full)
			begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_sel && w_strb[0])
				sel <= w_eff[7:0];
			if (wr_cmd)
				cmd_last <= w_eff;
		end
	end

	// read mux over the readback index
	logic [7:0]  ar_addr;
	logic [31:0] rd_word;
	logic        rd_map;
	assign ar_addr = {s_axi_araddr[7:2], 2'b00};
	assign rd_map  = ar_addr == REG_CTRL || ar_addr == REG_CMD || ar_addr == REG_SEL
		|| ar_addr == REG_TSTAT || ar_addr == REG_CSTAT || ar_addr == REG_STAT;
	always_comb
	begin
		rd_word = '0;
		case (ar_addr)
			REG_CMD:   rd_word = cmd_last;
			REG_SEL:   rd_word = {24'h0, sel};
			REG_TSTAT: rd_word = {13'h0, t_arm[sel], t_act[sel], t_q[sel], t_cur[sel]};
			REG_CSTAT: rd_word = {15'h0, c_q[sel], c_cur[sel]};
			REG_STAT:  rd_word = {29'h0, scan_pend, tick_pend, busy};
			default:   rd_word = '0;
		endcase
	end

	// read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

/* File: dv/ptcb_scan_model.sv */
// scan executor model: an axi4-lite master issuing the bank's accesses.
// assumes the bench calls wr and rd one at a time.
`timescale 1ns/1ps
module ptcb_scan_model
	import ptcb_pkg::*;
(
	input  wire logic        aclk,
	output logic      [7:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [7:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// idle bus at time zero
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
	end

	// write: handshakes sampled at negedge, acted on after the rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, b;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				{s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a}; // released lines lose the value
			if (tw)
				{s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
		end
		s_axi_bready <= 1'b0;
	endtask

	// read: address held until taken, data taken with rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, v;
		v = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!v)
		begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				{s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
		end
		s_axi_rready <= 1'b0;
	endtask
endmodule

/* File: dv/ptcb_bank_asserts.sv */
// checker of bus answers and of timer values read back.
// assumes it is bound to ptcb_bank and sees only its ports.
`timescale 1ns/1ps
module ptcb_bank_asserts
	import ptcb_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
)
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	logic [7:0] ar_q;
	wire        ar_ok = (ar_q[7:2] <= REG_STAT[7:2]);
	wire        ar_t  = (ar_q[7:2] == REG_TSTAT[7:2]);

	// address of the read in flight
	always_ff @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	ar_block_a: assert property (s_axi_arready != s_axi_rvalid)
		else $error("read address ready wrong");
	rd_map_a: assert property (s_axi_rvalid |-> s_axi_rresp == (ar_ok ? RESP_OKAY : RESP_SLVERR))
		else $error("read response code wrong");
	rd_bad_a: assert property (s_axi_rvalid && !ar_ok |-> s_axi_rdata == '0)
		else $error("unmapped read data not zero");
	b_after_a: assert property ($rose(s_axi_bvalid) |->
		$past(s_axi_awready) == 1'b0 && $past(s_axi_wready) == 1'b0)
		else $error("write answered before both parts taken");
	rst_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
		else $error("bus not idle after reset");
	tcur_sat_a: assert property (s_axi_rvalid && ar_t |-> !s_axi_rdata[15])
		else $error("timer value above maximum");

	rd_err_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	wr_err_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	tbit_c: cover property (s_axi_rvalid && ar_t && s_axi_rdata[16]);
endmodule

bind ptcb_bank ptcb_bank_asserts #(.MS_CYC(MS_CYC)) chk_i (.*);

/* File: dv/ptcb_bank_tb_top.sv */
// bench for the timer and counter bank: instructions and readback over axi4-lite.
// assumes a shortened millisecond tick; the scan model drives the bus.
`timescale 1ns/1ps
module ptcb_bank_tb_top
	import ptcb_pkg::*;
;
	localparam int MS = 300; // tick period in cycles, longer than one sweep
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          n_errors, checks;
	logic [3:0]  seq_bi [12] = '{4'h1, 4'h0, 4'h1, 4'h0, 4'h2, 4'h0,
		4'h3, 4'h0, 4'h2, 4'h0, 4'h2, 4'h0};

	ptcb_bank #(.MS_CYC(MS)) DUT (.*);
	ptcb_scan_model m (.*);

	// 10 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
		checks++;
		if (seen !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, seen);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one instruction; lv is {preload, reset, down, enable or up}
	task automatic ex(input logic [7:0] i, input logic [1:0] op, input logic [1:0] k,
		input logic [3:0] lv, input logic [15:0] p);
		ptcb_cmd_s c;
		c = ptcb_cmd_s'({p, lv, k, op, i});
		m.wr(REG_CMD, c, r);
	endtask

	// select an index and read one status word
	task automatic rs(input logic [7:0] i, input logic [7:0] a);
		m.wr(REG_SEL, {24'h0, i}, r);
		m.rd(a, d, r);
	endtask

	// compare value and bit of a status word
	task automatic sc(input string s, input logic [7:0] i, input logic [7:0] a,
		input logic [31:0] e);
		rs(i, a);
		chk(s, d & 32'h0001ffff, e);
	endtask

	// timer bit exact, value within lo..hi where tick phase is unknown
	task automatic rng(input string s, input logic [7:0] i, input logic b,
		input logic [15:0] lo, input logic [15:0] hi);
		rs(i, REG_TSTAT);
		chk(s, {31'h0, d[16] === b && d[15:0] >= lo && d[15:0] <= hi}, 32'h1);
	endtask

	task automatic ms(input int n);
		repeat (n * MS) @(posedge aclk);
	endtask

	// watchdog against a hung handshake
	initial
	begin
		repeat (90000) @(posedge aclk);
		n_errors++;
		conclude();
	end

	// main sequence
	initial
	begin
		aresetn = 1'b0;
		n_errors = 0;
		checks = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (300) @(posedge aclk);
		m.rd(REG_SEL, d, r);
		chk("sel reset", d, {24'h0, SEL_RST});
		m.rd(8'h20, d, r);
		chk("bad rd", {30'h0, r}, {30'h0, RESP_SLVERR});
		m.wr(8'h3c, 32'h1, r);
		chk("bad wr", {30'h0, r}, {30'h0, RESP_SLVERR});
		// counters
		repeat (3)
		begin
			ex(8'h05, OP_C_EXEC, CK_UP, 4'h0, 16'h2);
			ex(8'h05, OP_C_EXEC, CK_UP, 4'h1, 16'h2);
		end
		sc("up", 8'h05, REG_CSTAT, 32'h00010003);
		ex(8'h05, OP_C_EXEC, CK_UP, 4'h4, 16'h2);
		sc("up rst", 8'h05, REG_CSTAT, 32'h0);
		ex(8'hff, OP_C_EXEC, CK_UP, 4'h1, 16'h2);
		sc("c255", 8'hff, REG_CSTAT, 32'h1);
		foreach (seq_bi[j])
			ex(8'h06, OP_C_EXEC, CK_BI, seq_bi[j], 16'h1);
		sc("updn", 8'h06, REG_CSTAT, 32'h0000ffff);
		ex(8'h07, OP_C_EXEC, CK_DN, 4'h8, 16'h2);
		sc("dn load", 8'h07, REG_CSTAT, 32'h2);
		repeat (3)
		begin
			ex(8'h07, OP_C_EXEC, CK_DN, 4'h0, 16'h2);
			ex(8'h07, OP_C_EXEC, CK_DN, 4'h2, 16'h2);
		end
		sc("dn", 8'h07, REG_CSTAT, 32'h00010000);
		// reset instruction on a counter, and command readback
		ex(8'h07, OP_C_RESET, CK_DN, 4'h0, 16'h0);
		m.rd(REG_CMD, d, r);
		chk("cmd rb", d, 32'h00000b07);
		sc("c rst", 8'h07, REG_CSTAT, 32'h0);
		// 1 ms timers
		ex(8'h20, OP_T_EXEC, TK_ON, 4'h1, 16'h3);
		ms(5);
		rng("ton run", 8'h20, 1'b1, 16'h4, 16'h6);
		ex(8'h20, OP_T_EXEC, TK_ON, 4'h0, 16'h3);
		sc("ton off", 8'h20, REG_TSTAT, 32'h0);
		ex(8'h00, OP_T_EXEC, TK_ACC, 4'h1, 16'h2);
		ms(3);
		ex(8'h00, OP_T_EXEC, TK_ACC, 4'h0, 16'h2);
		ms(2);
		rng("tacc hold", 8'h00, 1'b1, 16'h2, 16'h4);
		ex(8'h00, OP_T_RESET, TK_ACC, 4'h0, 16'h2);
		sc("tacc rst", 8'h00, REG_TSTAT, 32'h0);
		ex(8'h60, OP_T_EXEC, TK_OFF, 4'h1, 16'h2);
		sc("tof on", 8'h60, REG_TSTAT, 32'h00010000);
		ex(8'h60, OP_T_EXEC, TK_OFF, 4'h0, 16'h2);
		ms(4);
		sc("tof end", 8'h60, REG_TSTAT, 32'h2);
		ex(8'h60, OP_T_RESET, TK_OFF, 4'h0, 16'h2);
		ex(8'h60, OP_T_EXEC, TK_OFF, 4'h0, 16'h2);
		ms(3);
		sc("tof idle", 8'h60, REG_TSTAT, 32'h0);
		// 10 ms timer between two scan starts
		m.wr(REG_CTRL, 32'h1, r);
		ex(8'h21, OP_T_EXEC, TK_ON, 4'h1, 16'h0064);
		ms(25);
		sc("t10 hold", 8'h21, REG_TSTAT, 32'h0);
		m.wr(REG_CTRL, 32'h1, r);
		ms(1);
		rng("t10 scan", 8'h21, 1'b0, 16'h2, 16'h3);
		// a scan span of over 100 ms holds one or two slow intervals
		ms(100);
		m.wr(REG_CTRL, 32'h1, r);
		// 100 ms timer, preset reached by the first strobe; each strobe adds the span again
		ex(8'h28, OP_T_EXEC, TK_ON, 4'h1, 16'h1);
		ms(3);
		ex(8'h28, OP_T_EXEC, TK_ON, 4'h1, 16'h1);
		rng("t100", 8'h28, 1'b1, 16'h2, 16'h4);
		conclude();
	end
endmodule
